/* afe_model.sv */
`timescale 1ns/10ps
// ****************************************
// Analog front end stand-in
// ****************************************
module afe_model #(
	parameter int COUNT_W = 16
) (
	// Clock
	input wire logic clk,
	// Scan control from the block
	input wire logic [3:0] afe_channel,
	input wire logic afe_sample,
	// Per-slot counts chosen by the bench
	input wire logic [COUNT_W-1:0] level [16],
	// Count back to the block
	output logic [COUNT_W-1:0] afe_count
);
	logic [COUNT_W-1:0] last = '0;

	// Remember the last count so the idle value can differ from it
	always_ff @(posedge clk) begin
		last <= afe_count;
	end

	// Valid only inside the window; outside it toggles every cycle
	assign afe_count = afe_sample ? level[afe_channel] : ~last;
endmodule // afe_model

/* chan_eval.sv */
`timescale 1ns/10ps
module chan_eval #(
	parameter int COUNT_W = 16
) (
	// Channel values
	input wire logic [COUNT_W-1:0] avg,
	input wire logic [COUNT_W-1:0] base,
	input wire logic [COUNT_W-1:0] prev,
	// Limits
	input wire logic [7:0] noise_lim,
	input wire logic [3:0] negative_delta_limit,
	input wire logic [3:0] negative_recal_limit,
	// Verdicts
	output logic noisy,
	output logic neg_delta_hit,
	output logic neg_recal_hit
);
	logic signed [COUNT_W:0] delta;
	logic signed [COUNT_W:0] diff;
	logic signed [COUNT_W:0] mag;
	logic signed [COUNT_W:0] negative_delta_limit_lim;
	logic signed [COUNT_W:0] negative_recal_limit_lim;
	logic negative_recal_limit_on;

	if (COUNT_W < 8) begin : g_bad_width
		$error("COUNT_W must be at least 8");
	end

	// Signed distances from baseline and from the last average
	assign delta = $signed({1'b0, avg}) - $signed({1'b0, base});
	assign diff = $signed({1'b0, avg}) - $signed({1'b0, prev});
	assign mag = diff < 0 ? -diff : diff;

	// Noise only judged with a limit in range
	assign noisy = !noise_lim[tsc_pkg::NOISE_BAD_BIT] &&
		mag > $signed((COUNT_W + 1)'(noise_lim));

	// Code n stands for a drop of n plus one
	assign negative_delta_limit_lim = $signed((COUNT_W + 1)'(negative_delta_limit) + (COUNT_W + 1)'(1));
	assign neg_delta_hit = delta < -negative_delta_limit_lim;

	// Codes above the top step behave as disabled
	assign negative_recal_limit_on = negative_recal_limit != 4'h0 && int'(negative_recal_limit) <= tsc_pkg::NEGATIVE_RECAL_LIMIT_MAX;
	assign negative_recal_limit_lim = $signed((COUNT_W + 1)'(int'(negative_recal_limit) * tsc_pkg::NEGATIVE_RECAL_LIMIT_STEP));
	assign neg_recal_hit = negative_recal_limit_on && delta < -negative_recal_limit_lim;
endmodule // chan_eval

/* tick_gen.sv */
`timescale 1ns/10ps
module tick_gen #(
	parameter int UNIT = 10
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Restart and unit strobe
	input wire logic restart,
	output logic tick
);
	localparam int W = $clog2(UNIT);
	typedef struct packed {
		logic [W-1:0] cnt;
	} tick_state_t;
	tick_state_t q;
	tick_state_t next_q;

	if (UNIT < 2) begin : g_bad_unit
		$error("UNIT must be at least 2");
	end

	// Unit counter, held at zero while restart is high
	always_comb begin
		next_q = q;
		if (restart || q.cnt == W'(UNIT - 1)) begin
			next_q.cnt = '0;
		end else begin
			next_q.cnt = q.cnt + 1'b1;
		end
	end

	// Strobe on the last cycle of each unit
	assign tick = !restart && q.cnt == W'(UNIT - 1);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end
endmodule // tick_gen

/* touch_scan_calibration.sv */
`timescale 1ns/10ps
module touch_scan_calibration #(
	parameter int COUNT_W = 16,
	parameter int SAMPLE_UNIT_CYCLES = tsc_pkg::SAMPLE_UNIT_CYC,
	parameter int PAUSE_UNIT_CYCLES = tsc_pkg::PAUSE_UNIT_CYC,
	parameter int HOLD_UNIT_CYCLES = tsc_pkg::HOLD_UNIT_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Long-hold controls
	input wire logic [3:0] hold_limit_time,
	input wire logic hold_limit_enable,
	// Key status
	input wire logic [tsc_pkg::NUM_KEYS-1:0] key_pressed,
	// Analog front end
	output logic [3:0] afe_channel,
	output logic ref_discharge,
	output logic afe_sample,
	input wire logic [COUNT_W-1:0] afe_count,
	output logic charge_target_select,
	output logic charge_source_select
);
	localparam int NK = tsc_pkg::NUM_KEYS;
	localparam int SUM_W = COUNT_W + 4;

	typedef struct packed {
		tsc_pkg::scan_state_t st;
		logic [3:0] slot;
		logic [4:0] samp;
		logic [2:0] units;
		logic [10:0] timer;
		logic [SUM_W-1:0] sum;
		logic [7:0] cfg_samp;
		logic [7:0] cfg_cal;
		logic [7:0] noise_lim;
		logic [7:0] neg_th;
		logic [7:0] scan_v;
		logic [NK-1:0] frc;
		logic [NK-1:0] noise;
		logic [NK-1:0] cal_ok;
		logic [NK-1:0] hold_due;
		logic [NK-1:0] idle_pend;
		logic [NK-1:0][COUNT_W-1:0] base;
		logic [NK-1:0][COUNT_W-1:0] prev;
		logic [NK-1:0][5:0] negcnt;
		logic [NK-1:0][4:0] holdcnt;
		logic [8:0] idle_cnt;
		logic [7:0] rdata;
	} state_t;

	state_t q;
	state_t next_q;
	logic samp_tick;
	logic pause_tick;
	logic hold_tick;
	logic [3:0] avg_code;
	logic [1:0] st_code;
	logic [1:0] cds_code;
	logic [2:0] csc_code;
	logic [1:0] ndc_code;
	logic [2:0] zt_code;
	logic [4:0] n_samp;
	logic [COUNT_W-1:0] avg;
	logic [10:0] disch_load;
	logic [4:0] hold_lim;
	logic [5:0] ndc_lim;
	logic [8:0] idle_lim;
	logic [5:0] new_neg;
	logic key_ok;
	logic noisy;
	logic neg_delta_hit;
	logic neg_recal_hit;
	logic recal;
	int st_age;
	logic cfg_seen;

	if (COUNT_W < 8 || COUNT_W > 24) begin : g_bad_width
		$error("COUNT_W must lie in 8 to 24");
	end

	// Window length code to a count of units
	function automatic logic [2:0] units_of(input logic [1:0] code);
		case (code)
			2'h0: units_of = 3'h1;
			2'h1: units_of = 3'h2;
			2'h2: units_of = 3'h4;
			default: units_of = 3'h6;
		endcase
	endfunction

	// ****************************************
	// Unit strobes
	// ****************************************
	tick_gen #(.UNIT(SAMPLE_UNIT_CYCLES)) u_samp_tick (
		.clk(clk),
		.rst_n(rst_n),
		.restart(q.st != tsc_pkg::ST_SAMPLE),
		.tick(samp_tick)
	);
	tick_gen #(.UNIT(PAUSE_UNIT_CYCLES)) u_pause_tick (
		.clk(clk),
		.rst_n(rst_n),
		.restart(q.st != tsc_pkg::ST_PAUSE),
		.tick(pause_tick)
	);
	tick_gen #(.UNIT(HOLD_UNIT_CYCLES)) u_hold_tick (
		.clk(clk),
		.rst_n(rst_n),
		.restart(1'b0),
		.tick(hold_tick)
	);

	// ****************************************
	// Field decode and channel evaluation
	// ****************************************
	assign avg_code = q.cfg_samp[tsc_pkg::AVG_LSB +: 4];
	assign st_code = q.cfg_samp[tsc_pkg::STIME_LSB +: 2];
	assign cds_code = q.cfg_samp[tsc_pkg::PAUSE_LSB +: 2];
	assign csc_code = q.cfg_cal[tsc_pkg::IDLE_LSB +: 3];
	assign ndc_code = q.cfg_cal[tsc_pkg::NDC_LSB +: 2];
	assign zt_code = q.scan_v[tsc_pkg::ZT_LSB +: 3];
	assign n_samp = 5'(avg_code) + 5'h01;
	assign avg = COUNT_W'(q.sum / SUM_W'(n_samp));
	assign disch_load =
		11'(tsc_pkg::DISCH_UNIT_CYC * (int'(zt_code) + 1) - 1);
	assign hold_lim = hold_limit_time == 4'h0 ? 5'h01 :
		{hold_limit_time, 1'b0};
	assign ndc_lim = 6'h04 << ndc_code;
	assign idle_lim = 9'h002 << csc_code;
	assign key_ok = q.slot < 4'(NK);

	chan_eval #(.COUNT_W(COUNT_W)) u_eval (
		.avg(avg),
		.base(q.base[q.slot]),
		.prev(q.prev[q.slot]),
		.noise_lim(q.noise_lim),
		.negative_delta_limit(q.neg_th[tsc_pkg::NEGATIVE_DELTA_LIMIT_LSB +: 4]),
		.negative_recal_limit(q.neg_th[tsc_pkg::NEGATIVE_RECAL_LIMIT_LSB +: 4]),
		.noisy(noisy),
		.neg_delta_hit(neg_delta_hit),
		.neg_recal_hit(neg_recal_hit)
	);

	assign new_neg = neg_delta_hit ? q.negcnt[q.slot] + 6'h01 : 6'h00;
	assign recal = !q.cal_ok[q.slot] || q.frc[q.slot]
		|| q.hold_due[q.slot] || q.idle_pend[q.slot]
		|| neg_recal_hit || new_neg >= ndc_lim;

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		next_q = q;
		// Long-hold timers for every key
		for (int k = 0; k < NK; k++) begin
			if (!key_pressed[k] || !hold_limit_enable) begin
				next_q.holdcnt[k] = 5'h00;
				next_q.hold_due[k] = 1'b0;
			end else if (hold_tick && !q.hold_due[k]) begin
				next_q.holdcnt[k] = q.holdcnt[k] + 5'h01;
				if (q.holdcnt[k] + 5'h01 >= hold_lim) begin
					next_q.hold_due[k] = 1'b1;
				end
			end
		end
		// Scan sequencer
		case (q.st)
			tsc_pkg::ST_PAUSE: begin
				if (pause_tick) begin
					next_q.units = q.units + 3'h1;
					if (q.units + 3'h1 >= units_of(cds_code)) begin
						next_q.st = tsc_pkg::ST_DISCH;
						next_q.units = 3'h0;
						next_q.slot = 4'h0;
						next_q.timer = disch_load;
					end
				end
			end
			tsc_pkg::ST_DISCH: begin
				if (q.timer == 11'h000) begin
					next_q.st = tsc_pkg::ST_SAMPLE;
				end else begin
					next_q.timer = q.timer - 11'h001;
				end
			end
			tsc_pkg::ST_SAMPLE: begin
				if (samp_tick) begin
					next_q.units = q.units + 3'h1;
					if (q.units + 3'h1 >= units_of(st_code)) begin
						next_q.units = 3'h0;
						next_q.sum = q.sum + SUM_W'(afe_count);
						next_q.samp = q.samp + 5'h01;
						next_q.timer = disch_load;
						if (q.samp + 5'h01 >= n_samp) begin
							next_q.st = tsc_pkg::ST_EVAL;
						end else begin
							next_q.st = tsc_pkg::ST_DISCH;
						end
					end
				end
			end
			default: begin
				if (key_ok) begin
					next_q.prev[q.slot] = avg;
					next_q.negcnt[q.slot] = new_neg;
					next_q.noise[q.slot] = q.cal_ok[q.slot] && noisy;
					if (recal) begin
						next_q.base[q.slot] = avg;
						next_q.negcnt[q.slot] = 6'h00;
						next_q.holdcnt[q.slot] = 5'h00;
						next_q.hold_due[q.slot] = 1'b0;
						next_q.idle_pend[q.slot] = 1'b0;
						next_q.frc[q.slot] = 1'b0;
						next_q.cal_ok[q.slot] = 1'b1;
					end
				end
				next_q.sum = '0;
				next_q.samp = 5'h00;
				next_q.timer = disch_load;
				next_q.slot = q.slot + 4'h1;
				next_q.st = tsc_pkg::ST_DISCH;
				if (q.slot == 4'(tsc_pkg::NUM_SLOTS - 1)) begin
					next_q.st = tsc_pkg::ST_PAUSE;
					next_q.slot = 4'h0;
					if (|key_pressed) begin
						next_q.idle_cnt = 9'h000;
					end else if (q.idle_cnt + 9'h001 >= idle_lim) begin
						next_q.idle_pend = '1;
						next_q.idle_cnt = 9'h000;
					end else begin
						next_q.idle_cnt = q.idle_cnt + 9'h001;
					end
				end
			end
		endcase
		// Register writes; a request written now beats the clear above
		if (reg_wr) begin
			if (reg_addr == tsc_pkg::ADDR_SAMPLING) begin
				next_q.cfg_samp = reg_wdata;
			end else if (reg_addr == tsc_pkg::ADDR_CAL) begin
				next_q.cfg_cal = reg_wdata & tsc_pkg::CAL_MASK;
			end else if (reg_addr == tsc_pkg::ADDR_FRC_LO) begin
				next_q.frc[7:0] = reg_wdata;
			end else if (reg_addr == tsc_pkg::ADDR_FRC_HI) begin
				next_q.frc[NK-1:8] = reg_wdata[NK-9:0];
			end else if (reg_addr == tsc_pkg::ADDR_NOISE_LIM) begin
				next_q.noise_lim = reg_wdata;
			end else if (reg_addr == tsc_pkg::ADDR_NEG_TH) begin
				next_q.neg_th = reg_wdata;
			end else if (reg_addr == tsc_pkg::ADDR_SCAN_V) begin
				next_q.scan_v = reg_wdata & tsc_pkg::SCAN_V_MASK;
			end
		end
		// Read data, unmapped offsets read as zero
		if (reg_rd) begin
			if (reg_addr == tsc_pkg::ADDR_SAMPLING) begin
				next_q.rdata = q.cfg_samp;
			end else if (reg_addr == tsc_pkg::ADDR_CAL) begin
				next_q.rdata = q.cfg_cal;
			end else if (reg_addr == tsc_pkg::ADDR_FRC_LO) begin
				next_q.rdata = q.frc[7:0];
			end else if (reg_addr == tsc_pkg::ADDR_FRC_HI) begin
				next_q.rdata = 8'({1'b0, q.frc[NK-1:8]});
			end else if (reg_addr == tsc_pkg::ADDR_NOISE_LIM) begin
				next_q.rdata = q.noise_lim;
			end else if (reg_addr == tsc_pkg::ADDR_NFLAG_LO) begin
				next_q.rdata = q.noise[7:0];
			end else if (reg_addr == tsc_pkg::ADDR_NFLAG_HI) begin
				next_q.rdata = 8'({1'b0, q.noise[NK-1:8]});
			end else if (reg_addr == tsc_pkg::ADDR_NEG_TH) begin
				next_q.rdata = q.neg_th;
			end else if (reg_addr == tsc_pkg::ADDR_SCAN_V) begin
				next_q.rdata = q.scan_v;
			end else begin
				next_q.rdata = tsc_pkg::REG_RESET;
			end
		end
	end

	// State register
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end

	// Outputs
	assign reg_rdata = q.rdata;
	assign afe_channel = q.slot;
	assign ref_discharge = q.st == tsc_pkg::ST_DISCH;
	assign afe_sample = q.st == tsc_pkg::ST_SAMPLE;
	assign charge_target_select = q.scan_v[tsc_pkg::VTH_BIT];
	assign charge_source_select = q.scan_v[tsc_pkg::CHARGE_SOURCE_SELECT_BIT];

	// ****************************************
	// Checks
	// ****************************************
	// Cycles spent in the current state
	always_ff @(posedge clk) begin
		if (!rst_n || next_q.st != q.st) begin
			st_age <= 0;
		end else begin
			st_age <= st_age + 1;
		end
	end

	// Timing fields rewritten during the current slot or pause
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cfg_seen <= 1'b0;
		end else if (reg_wr && (reg_addr == tsc_pkg::ADDR_SAMPLING
			|| reg_addr == tsc_pkg::ADDR_SCAN_V)) begin
			cfg_seen <= 1'b1;
		end else if (q.st == tsc_pkg::ST_EVAL) begin
			cfg_seen <= 1'b0;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	property p_sample_len;
		afe_sample && next_q.st != tsc_pkg::ST_SAMPLE && !cfg_seen |->
			st_age == int'(units_of(st_code)) * SAMPLE_UNIT_CYCLES - 1;
	endproperty
	a_sample_len: assert property (p_sample_len)
		else $error("sample window length wrong");
	property p_disch_len;
		ref_discharge && next_q.st != tsc_pkg::ST_DISCH && !cfg_seen |->
			st_age == tsc_pkg::DISCH_UNIT_CYC * (int'(zt_code) + 1) - 1;
	endproperty
	a_disch_len: assert property (p_disch_len)
		else $error("discharge length wrong");
	property p_pause_len;
		q.st == tsc_pkg::ST_PAUSE && next_q.st != tsc_pkg::ST_PAUSE
			&& !$rose(rst_n) && !cfg_seen |->
			st_age == int'(units_of(cds_code)) * PAUSE_UNIT_CYCLES - 1;
	endproperty
	a_pause_len: assert property (p_pause_len)
		else $error("cycle pause length wrong");
	property p_avg_count;
		$rose(q.st == tsc_pkg::ST_EVAL) && !cfg_seen |-> q.samp == n_samp;
	endproperty
	a_avg_count: assert property (p_avg_count)
		else $error("wrong number of samples averaged");
	property p_frc_clear;
		q.st == tsc_pkg::ST_EVAL && key_ok && q.frc[q.slot] && !reg_wr
			|=> !q.frc[$past(q.slot)] && q.base[$past(q.slot)] == $past(avg);
	endproperty
	a_frc_clear: assert property (p_frc_clear)
		else $error("request not served or not cleared");
	property p_recal_base;
		q.st == tsc_pkg::ST_EVAL && key_ok && recal |=>
			q.negcnt[$past(q.slot)] == 6'h00 && q.holdcnt[$past(q.slot)] == 5'h00;
	endproperty
	a_recal_base: assert property (p_recal_base)
		else $error("recalibration left counters set");
	property p_neg_recal;
		q.st == tsc_pkg::ST_EVAL && key_ok && neg_recal_hit |=>
			q.base[$past(q.slot)] == $past(avg);
	endproperty
	a_neg_recal: assert property (p_neg_recal)
		else $error("negative limit did not recalibrate");
	property p_hold_off;
		!hold_limit_enable |=> q.hold_due == '0;
	endproperty
	a_hold_off: assert property (p_hold_off)
		else $error("hold recalibration while disabled");
	property p_hold_release;
		##1 (q.hold_due & ~$past(key_pressed)) == '0;
	endproperty
	a_hold_release: assert property (p_hold_release)
		else $error("hold timer survived release");
	property p_hold_due;
		$rose(q.hold_due[0]) |-> q.holdcnt[0] >= hold_lim
			&& $past(q.holdcnt[0]) < hold_lim;
	endproperty
	a_hold_due: assert property (p_hold_due)
		else $error("hold limit reached at wrong count");
	property p_noise_off;
		q.st == tsc_pkg::ST_EVAL && key_ok && q.noise_lim > 8'h7f
			|=> !q.noise[$past(q.slot)];
	endproperty
	a_noise_off: assert property (p_noise_off)
		else $error("noise flagged with invalid limit");

	c_pause: cover property (q.st == tsc_pkg::ST_EVAL
		&& next_q.st == tsc_pkg::ST_PAUSE);
	c_frc: cover property (q.st == tsc_pkg::ST_EVAL && key_ok && q.frc[q.slot]);
	c_idle: cover property ($rose(q.idle_pend[0]));
	c_noise: cover property ($rose(q.noise[0]));
endmodule // touch_scan_calibration

/* touch_scan_calibration_bench.sv */
`timescale 1ns/10ps
module touch_scan_calibration_bench;
	// ****************************************
	// Signals and bench state
	// ****************************************
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic reg_wr = 1'b0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic [3:0] hold_limit_time = 4'h0;
	logic hold_limit_enable = 1'b0;
	logic [14:0] key_pressed = 15'h0000;
	logic [3:0] afe_channel;
	logic ref_discharge;
	logic afe_sample;
	logic [15:0] afe_count;
	logic charge_target_select;
	logic charge_source_select;
	logic [15:0] level [16];
	logic [15:0] seed = 16'h2ab8;
	logic [3:0] ch_prev = 4'h0;
	logic [7:0] addrs [12] = '{8'h0f, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14,
		8'h15, 8'h17, 8'h19, 8'h16, 8'h18, 8'h00};
	logic [7:0] masks [12] = '{8'hff, 8'h73, 8'hff, 8'h7f, 8'hff, 8'h00,
		8'h00, 8'hff, 8'hf8, 8'h00, 8'h00, 8'h00};
	int units [4] = '{1, 2, 4, 6};
	int nths [5] = '{5, 0, 127, 128, 255};
	int prev [16];
	int n_errors = 0;
	int n_compared = 0;
	int dis_run = 0, smp_run = 0, low_run = 0, nsmp = 0;
	int last_dis = 0, last_smp = 0, last_gap = 0, last_nsmp = 0;
	int slot_evt = 0, gap_evt = 0;

	// Clock of 50 ns period
	always #25 clk = ~clk;

	// ****************************************
	// Design and front end
	// ****************************************
	touch_scan_calibration #(
		.COUNT_W(16),
		.SAMPLE_UNIT_CYCLES(4),
		.PAUSE_UNIT_CYCLES(20),
		.HOLD_UNIT_CYCLES(50)
	) DUT (
		.clk(clk),
		.rst_n(rst_n),
		.reg_addr(reg_addr),
		.reg_wr(reg_wr),
		.reg_wdata(reg_wdata),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.hold_limit_time(hold_limit_time),
		.hold_limit_enable(hold_limit_enable),
		.key_pressed(key_pressed),
		.afe_channel(afe_channel),
		.ref_discharge(ref_discharge),
		.afe_sample(afe_sample),
		.afe_count(afe_count),
		.charge_target_select(charge_target_select),
		.charge_source_select(charge_source_select)
	);

	afe_model #(.COUNT_W(16)) front (
		.clk(clk),
		.afe_channel(afe_channel),
		.afe_sample(afe_sample),
		.level(level),
		.afe_count(afe_count)
	);

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	// Verdict and end of run
	task automatic finish_test;
		if (n_errors == 0 && n_compared > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("FAIL t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic chk_time(input int got, input int exp);
		n_compared++;
		if (got != exp) begin
			n_errors++;
			$display("FAIL t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	// One-cycle register strobes
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask

	// Wait for a new slot (0) or the end of a pause (1), bounded
	task automatic wait_evt(input int which);
		int start;
		start = which ? gap_evt : slot_evt;
		for (int i = 0; i < 30000; i++) begin
			@(posedge clk);
			#1;
			if ((which ? gap_evt : slot_evt) != start) return;
		end
		n_errors++;
		finish_test();
	endtask

	// Measure pulse widths, samples per slot and pause gaps
	always @(posedge clk) begin
		if (afe_channel !== ch_prev) begin
			last_nsmp = nsmp;
			nsmp = 0;
			slot_evt++;
		end
		ch_prev = afe_channel;
		if (ref_discharge) dis_run++;
		else if (dis_run > 0) begin
			last_dis = dis_run;
			dis_run = 0;
		end
		if (afe_sample) begin
			if (smp_run == 0) nsmp++;
			smp_run++;
		end else if (smp_run > 0) begin
			last_smp = smp_run;
			smp_run = 0;
		end
		if (!ref_discharge && !afe_sample) low_run++;
		else begin
			if (low_run > 1) begin
				last_gap = low_run;
				gap_evt++;
			end
			low_run = 0;
		end
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		logic [7:0] v;
		logic [14:0] nf;
		int d;
		int noise_limit;
		for (int k = 0; k < 16; k++) begin
			level[k] = 16'h03e8;
			prev[k] = 1000;
		end
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		// Reset values, then masked write and read back
		for (int i = 0; i < 12; i++) begin
			rd_reg(addrs[i], v);
			chk_reg(v, 8'h00);
		end
		for (int i = 0; i < 12; i++) begin
			seed = lfsr(seed);
			wr_reg(addrs[i], seed[7:0]);
			rd_reg(addrs[i], v);
			chk_reg(v, seed[7:0] & masks[i]);
		end
		// Charge target and source selects
		for (int j = 0; j < 4; j++) begin
			wr_reg(8'h19, {j[1], 3'h0, j[0], 3'h0});
			#1 chk_reg({6'h00, charge_target_select, charge_source_select},
				{6'h00, 2'(j)});
		end
		// Fast scan, settle all averages at the base level
		wr_reg(8'h0f, 8'h00);
		seed = lfsr(seed);
		wr_reg(8'h10, seed[7:0]);
		wr_reg(8'h17, seed[15:8]);
		key_pressed <= seed[14:0];
		hold_limit_enable <= seed[0];
		hold_limit_time <= seed[4:1];
		wait_evt(1);
		wait_evt(1);
		// Software requests, then noise rounds against the model
		wr_reg(8'h11, 8'hff);
		wr_reg(8'h12, 8'hff);
		rd_reg(8'h12, v);
		chk_reg(v, 8'h7f);
		for (int r = 0; r < 5; r++) begin
			noise_limit = nths[r];
			wr_reg(8'h13, 8'(noise_limit));
			// Change levels only at the start of a scan cycle
			wait_evt(1);
			for (int k = 0; k < 15; k++) begin
				seed = lfsr(seed);
				d = (k == 0) ? noise_limit : (k == 1) ? noise_limit + 1 : int'(seed[6:0]) - 64;
				nf[k] = (d > noise_limit || -d > noise_limit) && noise_limit <= 127;
				prev[k] += d;
				level[k] <= 16'(prev[k]);
			end
			key_pressed <= seed[14:0];
			wait_evt(1);
			rd_reg(8'h14, v);
			chk_reg(v, nf[7:0]);
			rd_reg(8'h15, v);
			chk_reg(v, {1'b0, nf[14:8]});
			if (r == 0) begin
				rd_reg(8'h11, v);
				chk_reg(v, 8'h00);
			end
		end
		// Pause between scan cycles for each code
		for (int c = 0; c < 4; c++) begin
			wr_reg(8'h0f, 8'(c));
			wait_evt(1);
			wait_evt(1);
			chk_time(last_gap, 1 + units[c] * 20);
		end
		// Discharge, sample window and sample count per slot
		for (int i = 0; i < 8; i++) begin
			wr_reg(8'h19, 8'((7 - i) << 4));
			wr_reg(8'h0f, 8'((((i == 7) ? 15 : i) << 4) | ((i % 4) << 2)));
			wait_evt(0);
			wait_evt(0);
			chk_time(last_dis, 8 * 20 * (8 - i));
			chk_time(last_smp, units[i % 4] * 4);
			chk_time(last_nsmp, (i == 7) ? 16 : i + 1);
		end
		finish_test();
	end
endmodule // touch_scan_calibration_bench

/* tsc_pkg.sv */
package tsc_pkg;
	// ****************************************
	// Clock and timing
	// ****************************************
	localparam int CLK_HZ = 20_000_000;
	localparam int SAMPLE_UNIT_US = 500;
	localparam int PAUSE_UNIT_MS = 50;
	localparam int HOLD_UNIT_MS = 500;
	localparam int DISCH_UNIT_NS = 8000;
	localparam int SAMPLE_UNIT_CYC = CLK_HZ / 1000 * SAMPLE_UNIT_US / 1000;
	localparam int PAUSE_UNIT_CYC = CLK_HZ / 1000 * PAUSE_UNIT_MS;
	localparam int HOLD_UNIT_CYC = CLK_HZ / 1000 * HOLD_UNIT_MS;
	localparam int DISCH_UNIT_CYC =
		(CLK_HZ / 1000 * DISCH_UNIT_NS + 999_999) / 1_000_000;

	// ****************************************
	// Register offsets, masks and reset value
	// ****************************************
	localparam logic [7:0] ADDR_SAMPLING = 8'h0f;
	localparam logic [7:0] ADDR_CAL = 8'h10;
	localparam logic [7:0] ADDR_FRC_LO = 8'h11;
	localparam logic [7:0] ADDR_FRC_HI = 8'h12;
	localparam logic [7:0] ADDR_NOISE_LIM = 8'h13;
	localparam logic [7:0] ADDR_NFLAG_LO = 8'h14;
	localparam logic [7:0] ADDR_NFLAG_HI = 8'h15;
	localparam logic [7:0] ADDR_NEG_TH = 8'h17;
	localparam logic [7:0] ADDR_SCAN_V = 8'h19;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [7:0] CAL_MASK = 8'h73;
	localparam logic [7:0] SCAN_V_MASK = 8'hf8;
	localparam logic [7:0] HIGH_MASK = 8'h7f;

	// ****************************************
	// Field positions and decode constants
	// ****************************************
	localparam int AVG_LSB = 4;
	localparam int STIME_LSB = 2;
	localparam int PAUSE_LSB = 0;
	localparam int IDLE_LSB = 4;
	localparam int NDC_LSB = 0;
	localparam int NEGATIVE_RECAL_LIMIT_LSB = 4;
	localparam int NEGATIVE_DELTA_LIMIT_LSB = 0;
	localparam int VTH_BIT = 7;
	localparam int ZT_LSB = 4;
	localparam int CHARGE_SOURCE_SELECT_BIT = 3;
	localparam int NOISE_BAD_BIT = 7;
	localparam int NUM_KEYS = 15;
	localparam int NUM_SLOTS = 16;
	localparam int NEGATIVE_RECAL_LIMIT_STEP = 10;
	localparam int NEGATIVE_RECAL_LIMIT_MAX = 12;

	typedef enum logic [1:0] {ST_PAUSE, ST_DISCH, ST_SAMPLE, ST_EVAL}
		scan_state_t;
endpackage
